// ==== inc/cca_pkg.sv ====
// cca_pkg: register map, field positions, reset values and mode decode for
// one capture/compare module of the counter array.
// assumes a 32-bit APB slave with byte addresses and one word per register.
`default_nettype none

package cca_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;  // module_mode_control
  localparam logic [7:0] OFS_CMP_LO = 8'h04;  // compare_low_byte / pwm_duty_byte
  localparam logic [7:0] OFS_CMP_HI = 8'h08;  // compare_high_byte / pwm_duty_shadow
  localparam logic [7:0] OFS_STATUS = 8'h0C;  // module_event_flag, write 1 to clear
  localparam logic [7:0] OFS_PIN    = 8'h10;  // pin levels, read only

  // module_mode_control field positions
  localparam int unsigned BIT_IRQ_EN = 0;  // module_irq_enable
  localparam int unsigned BIT_PWM    = 1;  // pwm_select
  localparam int unsigned BIT_TOG    = 2;  // match_toggle_enable
  localparam int unsigned BIT_MAT    = 3;  // match_flag_enable
  localparam int unsigned BIT_CAPN   = 4;  // falling_capture_enable
  localparam int unsigned BIT_CAPP   = 5;  // rising_capture_enable
  localparam int unsigned BIT_ECOM   = 6;  // comparator_enable

  // status and pin register field positions
  localparam int unsigned BIT_FLAG    = 0;  // module_event_flag
  localparam int unsigned BIT_PIN_IN  = 0;  // synchronised pin level
  localparam int unsigned BIT_PIN_OUT = 1;  // level the module drives

  // reset values
  localparam logic [7:0]  RST_MODE = 8'h00;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  WRAP_LOW = 8'h00;  // low byte value just after a wrap

  // decoded module function
  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_CAPTURE,
    MODE_TIMER,
    MODE_HSO,
    MODE_PWM
  } cca_mode_e;

endpackage : cca_pkg

`default_nettype wire

// ==== design/cca_sync.sv ====
// cca_sync: two-flop synchroniser for levels arriving from outside the clock.
// assumes the input is a slow level; the first flop feeds only the second.
`default_nettype none

module cca_sync #(
  parameter int unsigned WIDTH = 1  // number of independent levels
) (
  input  wire logic             clock_i,  // module clock
  input  wire logic             rst_i,    // synchronous, active high
  input  wire logic [WIDTH-1:0] async_i,  // level from a pin
  output logic      [WIDTH-1:0] sync_o    // level safe to use
);

  logic [WIDTH-1:0] meta_ff;  // first stage, may go metastable
  logic [WIDTH-1:0] sync_ff;  // second stage

  // two stages give a resolution window of a full clock period
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : cca_sync

`default_nettype wire

// ==== design/cca_module.sv ====
// cca_module: one capture/compare module of the counter array, APB slave.
// assumes the shared 16-bit counter lives outside on the same clock and
// pulses counter_tick_i in each cycle in which it shows a new value.
//
// Contract
// [RULE_01] mode bits 6..0 read zero after reset
// [RULE_02] software never writes reserved bit 7
// [RULE_03] reserved mode bit reads undefined
// [RULE_04] either capture edge bit selects capture
// [RULE_05] pin sampled, not used asynchronously
// [RULE_06] capture copies full 16-bit counter
// [RULE_07] rising-only setting captures rising edges
// [RULE_08] falling-only setting captures falling edges
// [RULE_09] both edge bits capture every transition
// [RULE_10] interrupt needs event flag and enable
// [RULE_11] comparator plus match makes software timer
// [RULE_12] timer compares counter every count
// [RULE_13] match bit lets equality set flag
// [RULE_14] toggle bit inverts pin on equality
// [RULE_15] toggle, match, comparator select high-speed output
// [RULE_16] high-speed output toggles on every match
// [RULE_17] all mode bits zero does nothing
// [RULE_18] comparator plus PWM selects 8-bit PWM
// [RULE_19] PWM low below duty, reload on wrap
// [RULE_20] hardware only sets the event flag
//
// The implementer's own choices: the APB slave port and the register addresses.
`default_nettype none

module cca_module
  import cca_pkg::*;
(
  input  wire logic        clock_i,            // module clock, 20 MHz
  input  wire logic        rst_i,              // synchronous, active high
  input  wire logic        psel_i,             // apb select
  input  wire logic        penable_i,          // apb access phase
  input  wire logic        pwrite_i,           // apb direction, 1 = write
  input  wire logic [7:0]  paddr_i,            // apb byte address
  input  wire logic [31:0] pwdata_i,           // apb write data
  output logic      [31:0] prdata_o,           // apb read data
  output logic             pready_o,           // apb ready
  output logic             pslverr_o,          // apb error, unmapped address
  input  wire logic [15:0] counter_value_i,    // shared counter, high and low byte
  input  wire logic        counter_tick_i,     // counter shows a new value
  input  wire logic        module_pin_i,       // pin level from the pad
  output logic             module_pin_o,       // level driven on the pin
  output logic             module_pin_oe_n_o,  // low while the module drives
  output logic             module_irq_o,       // interrupt request
  output logic             module_event_flag_o // flag for the shared control register
);

  // registers
  logic [7:0]  mode_ff;      // module_mode_control
  logic [7:0]  cmp_lo_ff;    // compare_low_byte, also pwm_duty_byte
  logic [7:0]  cmp_hi_ff;    // compare_high_byte, also pwm_duty_shadow
  logic        flag_ff;      // module_event_flag
  logic        irq_ff;       // registered interrupt request
  logic        pin_out_ff;   // driven pin level
  logic        pin_oen_ff;   // pin output enable, active low
  logic        pin_prev_ff;  // last synchronised pin level
  logic        pready_ff;    // apb ready, one wait state
  logic        pslverr_ff;   // apb error
  logic [31:0] prdata_ff;    // apb read data

  // combinational helpers
  cca_mode_e   mode_sel;     // decoded function
  logic        pin_sync;     // pin after two flops
  logic        rise_evt;     // rising edge seen on the pin
  logic        fall_evt;     // falling edge seen on the pin
  logic        capture_evt;  // capture this cycle
  logic        match_evt;    // counter equals compare this count
  logic        wrap_evt;     // low byte just wrapped to zero
  logic        apb_access;   // access phase
  logic        apb_commit;   // edge at which the transfer completes
  logic        addr_hit;     // address is mapped
  logic [31:0] rd_data;      // read mux
  logic        wr_mode;      // write strobes
  logic        wr_lo;
  logic        wr_hi;
  logic        flag_clear;   // software clears the flag
  logic        flag_set;     // hardware sets the flag

  // the pin crosses into the clock domain before any edge logic sees it
  cca_sync #(
    .WIDTH (1)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (module_pin_i),
    .sync_o  (pin_sync)
  );

  // mode decode; capture wins over any compare setting
  always_comb begin
    if (mode_ff[BIT_CAPP] || mode_ff[BIT_CAPN]) begin
      mode_sel = MODE_CAPTURE;  // RULE_04
    end else if (mode_ff[BIT_ECOM] && mode_ff[BIT_PWM] && !mode_ff[BIT_MAT] && !mode_ff[BIT_TOG]) begin
      mode_sel = MODE_PWM;  // RULE_18
    end else if (mode_ff[BIT_ECOM] && mode_ff[BIT_TOG] && !mode_ff[BIT_PWM]) begin
      mode_sel = MODE_HSO;  // RULE_15
    end else if (mode_ff[BIT_ECOM] && mode_ff[BIT_MAT] && !mode_ff[BIT_PWM]) begin
      mode_sel = MODE_TIMER;  // RULE_11
    end else begin
      mode_sel = MODE_IDLE;  // RULE_17
    end
  end

  // edge detection on the synchronised level only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_sync;  // RULE_05
    end
  end

  assign rise_evt = pin_sync && !pin_prev_ff;
  assign fall_evt = !pin_sync && pin_prev_ff;
  // only the edge directions that the mode enables may capture
  assign capture_evt = (mode_sel == MODE_CAPTURE) &&  // RULE_07 RULE_08 RULE_09
                       ((mode_ff[BIT_CAPP] && rise_evt) || (mode_ff[BIT_CAPN] && fall_evt));

  // equality is checked once per count so a stalled counter matches only once
  assign match_evt = ((mode_sel == MODE_TIMER) || (mode_sel == MODE_HSO)) && counter_tick_i &&
                     (counter_value_i == {cmp_hi_ff, cmp_lo_ff});  // RULE_12
  assign wrap_evt = counter_tick_i && (counter_value_i[7:0] == WRAP_LOW);

  // apb decode
  assign apb_access = psel_i && penable_i;
  assign apb_commit = apb_access && pready_ff;
  assign wr_mode    = apb_commit && pwrite_i && (paddr_i == OFS_MODE);
  assign wr_lo      = apb_commit && pwrite_i && (paddr_i == OFS_CMP_LO);
  assign wr_hi      = apb_commit && pwrite_i && (paddr_i == OFS_CMP_HI);
  assign flag_clear = apb_commit && pwrite_i && (paddr_i == OFS_STATUS) && pwdata_i[BIT_FLAG];
  assign flag_set   = capture_evt || (match_evt && mode_ff[BIT_MAT]);  // RULE_13

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_data  = RST_WORD;
    addr_hit = 1'b1;
    unique case (paddr_i)
      OFS_MODE:   rd_data[7:0] = mode_ff;  // RULE_03
      OFS_CMP_LO: rd_data[7:0] = cmp_lo_ff;
      OFS_CMP_HI: rd_data[7:0] = cmp_hi_ff;
      OFS_STATUS: rd_data[BIT_FLAG] = flag_ff;
      OFS_PIN: begin
        rd_data[BIT_PIN_IN]  = pin_sync;
        rd_data[BIT_PIN_OUT] = pin_out_ff;
      end
      default:    addr_hit = 1'b0;
    endcase
  end

  // apb handshake: ready rises one cycle into the access phase
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= RST_WORD;
    end else if (apb_access && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !addr_hit;
      prdata_ff  <= pwrite_i ? RST_WORD : rd_data;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // mode register; bit 7 is stored as written, its meaning is reserved
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_ff <= RST_MODE;  // RULE_01
    end else if (wr_mode) begin
      mode_ff <= pwdata_i[7:0];
    end
  end

  // compare/capture pair; a capture beats a software write in the same cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmp_lo_ff <= RST_BYTE;
      cmp_hi_ff <= RST_BYTE;
    end else if (capture_evt) begin
      cmp_hi_ff <= counter_value_i[15:8];  // RULE_06
      cmp_lo_ff <= counter_value_i[7:0];
    end else begin
      if ((mode_sel == MODE_PWM) && wrap_evt) begin
        cmp_lo_ff <= cmp_hi_ff;  // RULE_19
      end else if (wr_lo) begin
        cmp_lo_ff <= pwdata_i[7:0];
      end
      if (wr_hi) begin
        cmp_hi_ff <= pwdata_i[7:0];
      end
    end
  end

  // event flag: a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else if (flag_set) begin
      flag_ff <= 1'b1;
    end else if (flag_clear) begin
      flag_ff <= 1'b0;  // RULE_20
    end
  end

  // interrupt request follows flag and enable one cycle later
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && mode_ff[BIT_IRQ_EN];  // RULE_10
    end
  end

  // pin driver; in capture and idle modes the pin is left to the outside
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_out_ff <= 1'b0;
      pin_oen_ff <= 1'b1;
    end else begin
      pin_oen_ff <= !((mode_sel == MODE_HSO) || (mode_sel == MODE_PWM));
      if ((mode_sel == MODE_HSO) && match_evt) begin
        pin_out_ff <= !pin_out_ff;  // RULE_14 RULE_16
      end else if (mode_sel == MODE_PWM) begin
        pin_out_ff <= (counter_value_i[7:0] >= cmp_lo_ff);  // RULE_19
      end
    end
  end

  assign prdata_o            = prdata_ff;
  assign pready_o            = pready_ff;
  assign pslverr_o           = pslverr_ff;
  assign module_pin_o        = pin_out_ff;
  assign module_pin_oe_n_o   = pin_oen_ff;
  assign module_irq_o        = irq_ff;
  assign module_event_flag_o = flag_ff;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_reset_mode;
    $past(rst_i) |-> (mode_ff[6:0] == RST_MODE[6:0]);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not clear after reset"); // RULE_01

  property p_capture_rise;
    (mode_ff[6:0] == 7'h20) && rise_evt |=> ({cmp_hi_ff, cmp_lo_ff} == $past(counter_value_i)) && flag_ff;
  endproperty
  a_capture_rise: assert property (p_capture_rise) else $error("rising capture missed"); // RULE_07

  property p_capture_fall_only;
    (mode_ff[BIT_CAPN] && !mode_ff[BIT_CAPP]) && rise_evt |-> !capture_evt;
  endproperty
  a_capture_fall_only: assert property (p_capture_fall_only) else $error("rise captured in falling mode"); // RULE_08

  property p_capture_both;
    (mode_ff[BIT_CAPP] && mode_ff[BIT_CAPN]) && (pin_sync != pin_prev_ff) |=> flag_ff;
  endproperty
  a_capture_both: assert property (p_capture_both) else $error("transition not captured"); // RULE_09

  property p_irq_cause;
    module_irq_o |-> $past(flag_ff) && $past(mode_ff[BIT_IRQ_EN]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without flag and enable"); // RULE_10

  property p_timer_match;
    (mode_sel == MODE_TIMER) && counter_tick_i && (counter_value_i == {cmp_hi_ff, cmp_lo_ff}) |=> flag_ff;
  endproperty
  a_timer_match: assert property (p_timer_match) else $error("match did not set flag"); // RULE_13

  property p_hso_toggle;
    (mode_sel == MODE_HSO) && match_evt |=> (module_pin_o != $past(module_pin_o)) && !module_pin_oe_n_o;
  endproperty
  a_hso_toggle: assert property (p_hso_toggle) else $error("pin did not toggle on match"); // RULE_16

  property p_idle_quiet;
    (mode_ff[6:0] == 7'h00) && !flag_ff |=> !flag_ff ##0 module_pin_oe_n_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle module acted"); // RULE_17

  property p_pwm_level;
    (mode_sel == MODE_PWM) |=> module_pin_o == ($past(counter_value_i[7:0]) >= $past(cmp_lo_ff));
  endproperty
  a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong"); // RULE_19

  property p_pwm_reload;
    (mode_sel == MODE_PWM) && wrap_evt |=> (cmp_lo_ff == $past(cmp_hi_ff));
  endproperty
  a_pwm_reload: assert property (p_pwm_reload) else $error("duty not reloaded on wrap"); // RULE_19

  property p_capture_load;
    capture_evt |=> ({cmp_hi_ff, cmp_lo_ff} == $past(counter_value_i)) && flag_ff;
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture did not load counter"); // RULE_06

  property p_irq_raise;
    flag_ff && mode_ff[BIT_IRQ_EN] |=> module_irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised"); // RULE_10

  property p_flag_clear_only_sw;
    $fell(flag_ff) |-> $past(flag_clear) && !$past(flag_set);
  endproperty
  a_flag_clear_only_sw: assert property (p_flag_clear_only_sw) else $error("flag cleared by hardware"); // RULE_20

endmodule : cca_module

`default_nettype wire

// ==== dv/cca_pin_model.sv ====
// cca_pin_model: far side of the module pin, a driver that the bench steers.
// assumes the bench changes drive_en_i and level_i just after a rising edge.
`default_nettype none

module cca_pin_model (
  input  wire logic clock_i,       // module clock
  input  wire logic drive_en_i,    // far side drives the pad
  input  wire logic level_i,       // level the far side drives
  input  wire logic module_pin_i,  // level the module drives
  input  wire logic module_oe_n_i, // low while the module drives
  output logic      pad_o          // resolved pad level
);
  timeunit 1ns;
  timeprecision 1ns;

  logic float_ff = 1'b0;  // a released pad never holds its last value

  // flips every cycle so nothing may rely on a floating pad
  always_ff @(posedge clock_i) begin
    float_ff <= ~float_ff;
  end

  // the far side backs off whenever the module drives, avoiding contention
  always_comb begin
    if (!module_oe_n_i) begin
      pad_o = module_pin_i;
    end else if (drive_en_i) begin
      pad_o = level_i;
    end else begin
      pad_o = float_ff;
    end
  end
endmodule : cca_pin_model

`default_nettype wire

// ==== dv/counter_array_capture_compare_tb.sv ====
// counter_array_capture_compare_tb: self-checking bench for cca_module.
// assumes one clock, an APB answer after one wait state, and the pin model.
`default_nettype none

module counter_array_capture_compare_tb
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock_i = 1'b0;  // 20 MHz
  logic        rst_i   = 1'b1;  // synchronous, active high
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, ev, pin_o, oe_n, irq, flag, pad;
  logic [15:0] cv = 16'h0, cval, cmpv;  // counter driven into the module
  logic        ct = 1'b0;               // counter tick
  logic        flvl = 1'b0;             // far side pin level
  logic [7:0]  m, duty, nd, lo;
  logic        hit, expp;
  logic [7:0]  cmodes [3] = '{8'h20, 8'h10, 8'h31};  // rising, falling, both
  int          n_fail = 0, cmp_count = 0, cyc = 0;

  always #25 clock_i = ~clock_i;

  cca_module u_dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .counter_value_i(cv), .counter_tick_i(ct), .module_pin_i(pad),
    .module_pin_o(pin_o), .module_pin_oe_n_o(oe_n), .module_irq_o(irq), .module_event_flag_o(flag));

  cca_pin_model u_pin (.clock_i(clock_i), .drive_en_i(1'b1), .level_i(flvl),
    .module_pin_i(pin_o), .module_oe_n_i(oe_n), .pad_o(pad));

  // expected capture for an edge direction under a mode value
  function automatic logic cap_hit(input logic [7:0] md, input logic rise);
    return rise ? md[BIT_CAPP] : md[BIT_CAPN];
  endfunction : cap_hit

  // expected pwm level: low below duty, high at or above
  function automatic logic pwm_lvl(input logic [7:0] l, input logic [7:0] d);
    return (l >= d);
  endfunction : pwm_lvl

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // one apb transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk(32'(pready), 32'h1, "ready");
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setc(input logic [15:0] v, input logic t);
    @(posedge clock_i);
    cv <= v;
    ct <= t;
  endtask : setc

  // pin change then time for sync, edge detect and flag update
  task automatic pin(input logic l);
    @(posedge clock_i);
    flvl <= l;
    repeat (8) @(posedge clock_i);
  endtask : pin

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // hang guard: the whole run needs well under this many cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h27A6F6C1));
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    apb(1'b0, OFS_MODE, 32'h0);
    chk(32'(rv[6:0]), 32'(RST_MODE[6:0]), "mode reset");
    chk(32'(oe_n), 32'h1, "oe reset");
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(ev), 32'h1, "unmapped err");
    $display("test reset done");
    // bit 7 is never written by this bench
    apb(1'b1, OFS_MODE, 32'(RST_MODE));
    pin(1'b1);
    pin(1'b0);
    chk(32'(flag), 32'h0, "idle flag");
    $display("test idle done");
    foreach (cmodes[i]) begin
      m = cmodes[i];
      apb(1'b1, OFS_MODE, 32'(m));
      for (int k = 0; k < 2; k++) begin
        apb(1'b1, OFS_STATUS, 32'h1);
        cval = 16'($urandom);
        setc(cval, 1'b0);
        pin(k == 0);
        hit = cap_hit(m, k == 0);
        chk(32'(flag), 32'(hit), "capture flag");
        chk(32'(irq), 32'(hit & m[BIT_IRQ_EN]), "capture irq");
        if (hit) begin
          apb(1'b0, OFS_CMP_LO, 32'h0);
          chk(rv, 32'(cval[7:0]), "capture low");
          apb(1'b0, OFS_CMP_HI, 32'h0);
          chk(rv, 32'(cval[15:8]), "capture high");
        end
      end
    end
    $display("test capture done");
    cmpv = 16'($urandom_range(16'hFFF0, 16'h0010));
    apb(1'b1, OFS_CMP_LO, 32'(cmpv[7:0]));
    apb(1'b1, OFS_CMP_HI, 32'(cmpv[15:8]));
    apb(1'b1, OFS_MODE, 32'h49);
    apb(1'b1, OFS_STATUS, 32'h1);
    setc(cmpv, 1'b0);
    setc(cmpv - 16'h1, 1'b1);
    setc(cmpv + 16'h1, 1'b1);
    setc(cmpv + 16'h1, 1'b0);
    repeat (3) @(posedge clock_i);
    chk(32'(flag), 32'h0, "no false match");
    setc(cmpv, 1'b1);
    setc(cmpv, 1'b0);
    repeat (3) @(posedge clock_i);
    chk(32'(flag), 32'h1, "match flag");
    chk(32'(irq), 32'h1, "timer irq");
    chk(32'(oe_n), 32'h1, "timer leaves pin");
    repeat (8) @(posedge clock_i);
    chk(32'(flag), 32'h1, "flag kept");
    apb(1'b1, OFS_MODE, 32'h48);
    repeat (2) @(posedge clock_i);
    chk(32'(irq), 32'h0, "irq masked");
    $display("test timer done");
    apb(1'b1, OFS_MODE, 32'h4C);
    expp = 1'b0;
    for (int k = 0; k < 3; k++) begin
      setc(cmpv, 1'b1);
      setc(cmpv + 16'h1, 1'b0);
      repeat (3) @(posedge clock_i);
      expp = ~expp;
      chk(32'(pin_o), 32'(expp), "toggle");
    end
    chk(32'(oe_n), 32'h0, "hso drives");
    apb(1'b0, OFS_PIN, 32'h0);
    chk(32'(rv[BIT_PIN_IN]), 32'(expp), "pad level");
    $display("test hso done");
    duty = 8'($urandom_range(8'h7F, 8'h01));
    apb(1'b1, OFS_CMP_LO, 32'(duty));
    apb(1'b1, OFS_CMP_HI, 32'(duty));
    apb(1'b1, OFS_MODE, 32'h42);
    for (int k = 0; k < 12; k++) begin
      case (k)
        0: lo = 8'h00;
        1: lo = duty - 8'h1;
        2: lo = duty;
        3: lo = 8'hFF;
        default: lo = 8'($urandom);
      endcase
      setc({8'h5A, lo}, 1'b0);
      repeat (3) @(posedge clock_i);
      chk(32'(pin_o), 32'(pwm_lvl(lo, duty)), "pwm level");
    end
    chk(32'(oe_n), 32'h0, "pwm drives");
    nd = duty + 8'h80;
    apb(1'b1, OFS_CMP_HI, 32'(nd));
    setc(16'h5A00, 1'b1);
    setc(16'h5A00 | 16'(nd - 8'h1), 1'b0);
    repeat (3) @(posedge clock_i);
    chk(32'(pin_o), 32'h0, "reload below");
    setc(16'h5A00 | 16'(nd), 1'b0);
    repeat (3) @(posedge clock_i);
    chk(32'(pin_o), 32'h1, "reload at duty");
    $display("test pwm done");
    // reset again mid-run: the module must come back idle and quiet
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    apb(1'b0, OFS_MODE, 32'h0);
    chk(32'(rv[6:0]), 32'(RST_MODE[6:0]), "mode after reset");
    chk(32'(oe_n), 32'h1, "oe after reset");
    chk(32'(flag), 32'h0, "flag after reset");
    chk(32'(irq), 32'h0, "irq after reset");
    $display("test reset again done");
    give_verdict();
  end
endmodule : counter_array_capture_compare_tb

`default_nettype wire
